// *** hdl/pwm_output_and_trigger_control.v ***
// Output steering, fault forcing and ADC trigger logic of one PWM generator.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_out_trig_defs.vh"

// ==========================================================================
// Output and trigger control
module pwm_output_and_trigger_control (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire module_enable,
  input wire [15:0] time_base,
  input wire cycle_start,
  input wire gen_high,
  input wire gen_low,
  input wire secondary_trigger_event,
  input wire fault_in,
  input wire limit_in,
  input wire gpio_high,
  input wire gpio_low,
  output reg high_side_output,
  output reg low_side_output,
  output reg high_pin_oe,
  output reg low_pin_oe,
  output reg adc_trigger,
  output reg adc_trigger_secondary,
  output reg trigger_irq,
  output wire [13:0] alt_dead_time_value
);

  // ========================================================================
  // Helpers
  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [15:0] mask;
    reg [15:0] v;
    begin
      v = old;
      if (strb[0]) begin
        v[7:0] = data[7:0];
      end
      if (strb[1]) begin
        v[15:8] = data[15:8];
      end
      merge = v & mask;
    end
  endfunction

  function [3:0] word_index;
    input [31:0] addr;
    begin
      if (addr[31:6] != 26'h0 || addr[1:0] != 2'h0) begin
        word_index = 4'hf;
      end else begin
        word_index = addr[5:2];
      end
    end
  endfunction

  // ========================================================================
  // Registers
  reg [15:0] alt_dead_time_q;
  reg [15:0] trigger_control_q;
  reg [15:0] output_pin_control_q;
  reg [15:0] primary_trigger_compare_q;
  reg [15:0] fault_control_q;
  reg fault_latched_q;
  reg cycle_fault_q;
  reg trigger_armed_q;

  assign alt_dead_time_value = alt_dead_time_q[13:0];

  wire [3:0] trigger_divider = trigger_control_q[`TRG_DIV_HI:`TRG_DIV_LO];
  wire dual_trigger_combine = trigger_control_q[`TRG_DUAL_BIT];
  wire [5:0] trigger_start_delay =
    trigger_control_q[`TRG_START_HI:`TRG_START_LO];
  wire high_pin_own = output_pin_control_q[`IO_HIGH_OWN_BIT];
  wire low_pin_own = output_pin_control_q[`IO_LOW_OWN_BIT];
  wire high_pin_polarity = output_pin_control_q[`IO_HIGH_POL_BIT];
  wire low_pin_polarity = output_pin_control_q[`IO_LOW_POL_BIT];
  wire [1:0] pair_output_mode =
    output_pin_control_q[`IO_MODE_HI:`IO_MODE_LO];
  wire [1:0] fault_pin_state =
    output_pin_control_q[`IO_FAULT_HI:`IO_FAULT_LO];
  wire [1:0] limit_pin_state =
    output_pin_control_q[`IO_LIMIT_HI:`IO_LIMIT_LO];
  wire swap_pins = output_pin_control_q[`IO_SWAP_BIT];
  wire override_sync = output_pin_control_q[`IO_SYNC_BIT];
  wire independent_fault_select = fault_control_q[`FC_INDEP_BIT];
  wire current_limit_enable = fault_control_q[`FC_LIMIT_EN_BIT];
  wire [1:0] fault_mode_select = fault_control_q[`FC_MODE_HI:`FC_MODE_LO];

  // ========================================================================
  // AXI4-Lite slave
  reg aw_held_q;
  reg w_held_q;
  reg [31:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire aw_now = aw_held_q || s_axi_awvalid;
  wire w_now = w_held_q || s_axi_wvalid;
  wire do_write = aw_now && w_now && !s_axi_bvalid;
  wire [31:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire [3:0] wr_idx = word_index(wr_addr);
  wire wr_mapped = wr_idx <= `OFS_STATUS;
  wire status_clear = do_write && wr_idx == `OFS_STATUS &&
    wr_strb[0] && wr_data[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 32'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      alt_dead_time_q <= `RST_ALT_DEAD_TIME;
      trigger_control_q <= `RST_TRIGGER_CONTROL;
      output_pin_control_q <= `RST_OUTPUT_PIN_CONTROL;
      primary_trigger_compare_q <= `RST_PRIMARY_TRIGGER_COMPARE;
      fault_control_q <= `RST_FAULT_CONTROL;
    end else if (do_write) begin
      if (wr_idx == `OFS_ALT_DEAD_TIME) begin
        alt_dead_time_q <= merge(alt_dead_time_q, wr_data, wr_strb,
          `MSK_ALT_DEAD_TIME);
      end else if (wr_idx == `OFS_TRIGGER_CONTROL) begin
        trigger_control_q <= merge(trigger_control_q, wr_data, wr_strb,
          `MSK_TRIGGER_CONTROL);
      end else if (wr_idx == `OFS_OUTPUT_PIN_CONTROL) begin
        // Pair mode stays writable while enabled; software keeps off it.
        output_pin_control_q <= merge(output_pin_control_q, wr_data,
          wr_strb, `MSK_OUTPUT_PIN_CONTROL);
      end else if (wr_idx == `OFS_PRIMARY_TRIGGER_COMPARE) begin
        primary_trigger_compare_q <= merge(primary_trigger_compare_q,
          wr_data, wr_strb, `MSK_PRIMARY_TRIGGER_COMPARE);
      end else if (wr_idx == `OFS_FAULT_CONTROL) begin
        fault_control_q <= merge(fault_control_q, wr_data, wr_strb,
          `MSK_FAULT_CONTROL);
      end
    end
  end

  reg [15:0] rd_word;
  wire [3:0] rd_idx = word_index(s_axi_araddr);

  always @* begin
    rd_word = 16'h0000;
    if (rd_idx == `OFS_ALT_DEAD_TIME) begin
      rd_word = alt_dead_time_q;
    end else if (rd_idx == `OFS_TRIGGER_CONTROL) begin
      rd_word = trigger_control_q;
    end else if (rd_idx == `OFS_OUTPUT_PIN_CONTROL) begin
      rd_word = output_pin_control_q;
    end else if (rd_idx == `OFS_PRIMARY_TRIGGER_COMPARE) begin
      rd_word = primary_trigger_compare_q;
    end else if (rd_idx == `OFS_FAULT_CONTROL) begin
      rd_word = fault_control_q;
    end else if (rd_idx == `OFS_STATUS) begin
      rd_word = {11'h000, low_side_output, high_side_output,
        trigger_armed_q, cycle_fault_q, fault_latched_q};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_idx <= `OFS_STATUS ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Fault and current-limit inputs
  reg [1:0] fault_sync_q;
  reg [1:0] limit_sync_q;
  wire fault_now = fault_sync_q[1];
  wire limit_now = limit_sync_q[1] && current_limit_enable;

  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_sync_q <= 2'b00;
      limit_sync_q <= 2'b00;
    end else begin
      fault_sync_q <= {fault_sync_q[0], fault_in};
      limit_sync_q <= {limit_sync_q[0], limit_in};
    end
  end

  // A new fault wins over a clear written in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_latched_q <= 1'b0;
      cycle_fault_q <= 1'b0;
    end else begin
      if (fault_mode_select == `FAULT_LATCHED && fault_now) begin
        fault_latched_q <= 1'b1;
      end else if (status_clear || fault_mode_select != `FAULT_LATCHED) begin
        fault_latched_q <= 1'b0;
      end
      if (fault_mode_select == `FAULT_CYCLE && fault_now) begin
        cycle_fault_q <= 1'b1;
      end else if (cycle_start || fault_mode_select != `FAULT_CYCLE) begin
        cycle_fault_q <= 1'b0;
      end
    end
  end

  // Reserved mode 10 behaves as disabled.
  wire fault_force = fault_mode_select == `FAULT_LATCHED ?
    (fault_now || fault_latched_q) :
    fault_mode_select == `FAULT_CYCLE ? (fault_now || cycle_fault_q) :
    1'b0;

  // ========================================================================
  // Pair mode shaping
  reg push_phase_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      push_phase_q <= 1'b0;
    end else if (cycle_start) begin
      push_phase_q <= !push_phase_q;
    end
  end

  reg pair_high;
  reg pair_low;

  always @* begin
    pair_high = gen_high;
    pair_low = gen_low;
    case (pair_output_mode)
      `PAIR_COMPLEMENTARY: begin
        pair_low = !gen_high;
      end
      `PAIR_REDUNDANT: begin
        pair_low = gen_high;
      end
      `PAIR_PUSH_PULL: begin
        pair_high = gen_high && !push_phase_q;
        pair_low = gen_high && push_phase_q;
      end
      default: begin
        pair_low = gen_low;
      end
    endcase
  end

  // ========================================================================
  // Override staging
  reg [3:0] override_q;
  wire [3:0] override_reg = {output_pin_control_q[`IO_HIGH_OVR_BIT],
    output_pin_control_q[`IO_LOW_OVR_BIT],
    output_pin_control_q[`IO_OVR_HI:`IO_OVR_LO]};
  wire [3:0] override_eff = override_sync ? override_q : override_reg;

  // Synchronised overrides wait for the cycle boundary to avoid runt pulses.
  always @(posedge aclk) begin
    if (!aresetn) begin
      override_q <= 4'h0;
    end else if (cycle_start || !override_sync) begin
      override_q <= override_reg;
    end
  end

  // ========================================================================
  // Output selection
  reg sel_high;
  reg sel_low;
  reg phys_high;
  reg phys_low;

  always @* begin
    sel_high = pair_high;
    sel_low = pair_low;
    if (override_eff[3]) begin
      sel_high = override_eff[1];
    end
    if (override_eff[2]) begin
      sel_low = override_eff[0];
    end
    if (independent_fault_select) begin
      if (limit_now) begin
        sel_high = fault_pin_state[1];
      end
      if (fault_force) begin
        sel_low = fault_pin_state[0];
      end
    end else if (fault_force) begin
      sel_high = fault_pin_state[1];
      sel_low = fault_pin_state[0];
    end else if (limit_now) begin
      sel_high = limit_pin_state[1];
      sel_low = limit_pin_state[0];
    end
    if (swap_pins) begin
      phys_high = sel_low;
      phys_low = sel_high;
    end else begin
      phys_high = sel_high;
      phys_low = sel_low;
    end
    phys_high = phys_high ^ high_pin_polarity;
    phys_low = phys_low ^ low_pin_polarity;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
      high_pin_oe <= 1'b0;
      low_pin_oe <= 1'b0;
    end else begin
      high_side_output <= high_pin_own ? phys_high : gpio_high;
      low_side_output <= low_pin_own ? phys_low : gpio_low;
      high_pin_oe <= high_pin_own;
      low_pin_oe <= low_pin_own;
    end
  end

  // ========================================================================
  // Trigger path
  reg enable_seen_q;
  reg [5:0] start_count_q;
  reg [3:0] event_count_q;

  wire primary_match = module_enable &&
    time_base == primary_trigger_compare_q;
  wire primary_event = primary_match && trigger_armed_q;
  wire secondary_ok = secondary_trigger_event && module_enable &&
    trigger_armed_q;
  wire divider_hit = primary_event && event_count_q == trigger_divider;

  // The delay restarts each time the module is enabled again.
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_seen_q <= 1'b0;
      trigger_armed_q <= 1'b0;
      start_count_q <= 6'h00;
    end else begin
      enable_seen_q <= module_enable;
      if (!module_enable) begin
        trigger_armed_q <= 1'b0;
        start_count_q <= 6'h00;
      end else if (!enable_seen_q) begin
        trigger_armed_q <= trigger_start_delay == 6'h00;
      end else if (!trigger_armed_q && cycle_start) begin
        if (start_count_q + 6'h01 >= trigger_start_delay) begin
          trigger_armed_q <= 1'b1;
        end
        start_count_q <= start_count_q + 6'h01;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || !module_enable) begin
      event_count_q <= 4'h0;
    end else if (divider_hit) begin
      event_count_q <= 4'h0;
    end else if (primary_event) begin
      event_count_q <= event_count_q + 4'h1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      adc_trigger <= 1'b0;
      adc_trigger_secondary <= 1'b0;
      trigger_irq <= 1'b0;
    end else begin
      adc_trigger <= divider_hit ||
        (dual_trigger_combine && secondary_ok);
      adc_trigger_secondary <= !dual_trigger_combine && secondary_ok;
      trigger_irq <= divider_hit;
    end
  end

endmodule
`default_nettype wire

// *** hdl/pwm_out_trig_defs.vh ***
// Constants for the PWM output and trigger control block.
`ifndef PWM_OUT_TRIG_DEFS_VH
`define PWM_OUT_TRIG_DEFS_VH

// ==========================================================================
// Register word indices
// ==========================================================================
`define OFS_ALT_DEAD_TIME 4'h0
`define OFS_TRIGGER_CONTROL 4'h1
`define OFS_OUTPUT_PIN_CONTROL 4'h2
`define OFS_PRIMARY_TRIGGER_COMPARE 4'h3
`define OFS_FAULT_CONTROL 4'h4
`define OFS_STATUS 4'h5

// ==========================================================================
// Reset values and writable masks
// ==========================================================================
`define RST_ALT_DEAD_TIME 16'h0000
`define RST_TRIGGER_CONTROL 16'h0000
`define RST_OUTPUT_PIN_CONTROL 16'hc000
`define RST_PRIMARY_TRIGGER_COMPARE 16'h0000
`define RST_FAULT_CONTROL 16'h0000
`define MSK_ALT_DEAD_TIME 16'h3fff
`define MSK_TRIGGER_CONTROL 16'hf0bf
`define MSK_OUTPUT_PIN_CONTROL 16'hffff
`define MSK_PRIMARY_TRIGGER_COMPARE 16'hfff8
`define MSK_FAULT_CONTROL 16'h8103

// ==========================================================================
// Field positions
// ==========================================================================
`define TRG_DIV_HI 15
`define TRG_DIV_LO 12
`define TRG_DUAL_BIT 7
`define TRG_START_HI 5
`define TRG_START_LO 0
`define IO_HIGH_OWN_BIT 15
`define IO_LOW_OWN_BIT 14
`define IO_HIGH_POL_BIT 13
`define IO_LOW_POL_BIT 12
`define IO_MODE_HI 11
`define IO_MODE_LO 10
`define IO_HIGH_OVR_BIT 9
`define IO_LOW_OVR_BIT 8
`define IO_OVR_HI 7
`define IO_OVR_LO 6
`define IO_FAULT_HI 5
`define IO_FAULT_LO 4
`define IO_LIMIT_HI 3
`define IO_LIMIT_LO 2
`define IO_SWAP_BIT 1
`define IO_SYNC_BIT 0
`define FC_INDEP_BIT 15
`define FC_LIMIT_EN_BIT 8
`define FC_MODE_HI 1
`define FC_MODE_LO 0

// ==========================================================================
// Encodings
// ==========================================================================
`define PAIR_COMPLEMENTARY 2'h0
`define PAIR_REDUNDANT 2'h1
`define PAIR_PUSH_PULL 2'h2
`define PAIR_INDEPENDENT 2'h3
`define FAULT_LATCHED 2'h0
`define FAULT_CYCLE 2'h1
`define FAULT_DISABLED 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** dv/pwm_out_trig_monitor.sv ***
// Port-level assertions for the PWM output and trigger control block.
`timescale 1ns/1ps
`default_nettype none
module pwm_out_trig_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] time_base,
  input wire secondary_trigger_event,
  input wire gpio_high,
  input wire high_side_output,
  input wire high_pin_oe,
  input wire adc_trigger,
  input wire adc_trigger_secondary,
  input wire trigger_irq,
  input wire [13:0] alt_dead_time_value
);
  // ==========
  // Properties
  // ==========
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wr_hs = (s_axi_awvalid && s_axi_awready) ||
    (s_axi_wvalid && s_axi_wready);
  wire cmp_low = time_base[2:0] == 3'h0;
  wire any_evt = cmp_low || secondary_trigger_event;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_write_answer;
    s_wr_taken |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing");
  property p_read_answer;
    s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read response missing or wide");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read response dropped");
  property p_irq_primary;
    trigger_irq |-> adc_trigger && $past(cmp_low);
  endproperty
  a_irq_primary: assert property (p_irq_primary)
    else $error("interrupt without primary match");
  property p_secondary_cause;
    adc_trigger_secondary |-> $past(secondary_trigger_event);
  endproperty
  a_secondary_cause: assert property (p_secondary_cause)
    else $error("secondary trigger without event");
  property p_trigger_cause;
    adc_trigger |-> $past(any_evt);
  endproperty
  a_trigger_cause: assert property (p_trigger_cause)
    else $error("trigger without compare match");
  property p_gpio_high;
    !high_pin_oe && $past(aresetn) |-> high_side_output == $past(gpio_high);
  endproperty
  a_gpio_high: assert property (p_gpio_high)
    else $error("released pin not following port data");
  property p_alt_dt_write;
    !$stable(alt_dead_time_value) |-> $past(wr_hs) || $past(wr_hs, 2);
  endproperty
  a_alt_dt_write: assert property (p_alt_dt_write)
    else $error("dead time changed without write");
endmodule
`default_nettype wire

// *** dv/pwm_time_base_model.sv ***
// Behavioural PWM time base feeding the block's timing inputs.
`timescale 1ns/1ps
`default_nettype none
module pwm_time_base_model #(
  parameter int PERIOD = 32,
  parameter int SEC_AT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [15:0] time_base,
  output logic cycle_start,
  output logic secondary_trigger_event
);
  logic [15:0] count_q;
  always @(posedge aclk) begin
    if (!aresetn || count_q == 16'(PERIOD - 1))
      count_q <= 16'h0000;
    else
      count_q <= count_q + 16'h0001;
  end
  assign time_base = count_q;
  assign cycle_start = count_q == 16'h0000;
  assign secondary_trigger_event = count_q == 16'(SEC_AT);
endmodule
`default_nettype wire

// *** dv/pwm_output_and_trigger_control_test.sv ***
// Self-checking testbench of the PWM output and trigger control block.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_out_trig_defs.vh"
module pwm_output_and_trigger_control_test;
  localparam int PER = 32;
  localparam logic [15:0] RSTV [4] = '{`RST_ALT_DEAD_TIME,
    `RST_TRIGGER_CONTROL, `RST_OUTPUT_PIN_CONTROL,
    `RST_PRIMARY_TRIGGER_COMPARE};
  localparam logic [15:0] MSKV [4] = '{`MSK_ALT_DEAD_TIME,
    `MSK_TRIGGER_CONTROL, `MSK_OUTPUT_PIN_CONTROL,
    `MSK_PRIMARY_TRIGGER_COMPARE};
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, module_enable = 1'b0;
  logic fault_in = 1'b0, limit_in = 1'b0, gen_high = 1'b0, gen_low = 1'b0;
  logic gpio_high = 1'b0, gpio_low = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_q;
  logic [15:0] lfsr_q = 16'h5c55;
  logic [1:0] resp_q;
  wire awready, wready, bvalid, arready, rvalid, cycle_start, sec_evt;
  wire hout, lout, hoe, loe, trg, trg2, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] time_base;
  wire [13:0] alt_dt;
  int miscompares = 0, check_count = 0, n_trg = 0, n_sec = 0, n_irq = 0;

  pwm_time_base_model #(.PERIOD(PER), .SEC_AT(4)) i_tbase (.aclk(aclk),
    .aresetn(aresetn), .time_base(time_base), .cycle_start(cycle_start),
    .secondary_trigger_event(sec_evt));
  pwm_output_and_trigger_control i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_enable(module_enable), .time_base(time_base),
    .cycle_start(cycle_start), .gen_high(gen_high), .gen_low(gen_low),
    .secondary_trigger_event(sec_evt), .fault_in(fault_in),
    .limit_in(limit_in), .gpio_high(gpio_high), .gpio_low(gpio_low),
    .high_side_output(hout), .low_side_output(lout), .high_pin_oe(hoe),
    .low_pin_oe(loe), .adc_trigger(trg), .adc_trigger_secondary(trg2),
    .trigger_irq(irq), .alt_dead_time_value(alt_dt));

  // ==========
  // Helpers
  // ==========
  initial forever #25 aclk = ~aclk;
  // Counted mid-cycle, clear of rising-edge snapshots.
  always @(negedge aclk) begin
    n_trg += trg;
    n_sec += trg2;
    n_irq += irq;
  end
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  // s packs fault, limit, generator and port bits, high first.
  function automatic logic [1:0] exp_pins(input logic [15:0] io, fc,
      input logic [5:0] s);
    logic [1:0] p;
    logic fa, la;
    fa = s[5] && !fc[1];
    la = s[4] && fc[8];
    p = io[11:10] == 2'h0 ? {s[3], ~s[3]} :
      io[11:10] == 2'h1 ? {2{s[3]}} : s[3:2];
    if (io[9]) p[1] = io[7];
    if (io[8]) p[0] = io[6];
    if (!fc[15] && la) p = io[3:2];
    if (!fc[15] && fa) p = io[5:4];
    if (fc[15] && la) p[1] = io[5];
    if (fc[15] && fa) p[0] = io[4];
    if (io[1]) p = {p[0], p[1]};
    p = p ^ io[13:12];
    if (!io[15]) p[1] = s[1];
    if (!io[14]) p[0] = s[0];
    return p;
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Ready lags the response a cycle, so each response must stand.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, tw, bv, br;
    awaddr <= {24'h0, a};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      bv = bvalid;
      br = bready;
      resp_q = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= bv && !br;
    end while (!(bv && br));
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, rv, rr;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arready;
      rv = rvalid;
      rr = rready;
      rd_q = rdata;
      resp_q = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= rv && !rr;
    end while (!(rv && rr));
  endtask
  task automatic pins(input logic [1:0] e);
    @(negedge aclk);
    chk({hout, lout}, e, "pins");
    @(posedge aclk);
  endtask
  // Windows span whole divider periods, so the count is phase independent.
  task automatic run_trig(input logic [3:0] d, input logic [5:0] s,
      input logic dm);
    int c0, c1, c2;
    module_enable <= 1'b0;
    wr(8'h0c, 16'h0010);
    wr(8'h04, {d, 4'h0, dm, 1'b0, s});
    module_enable <= 1'b1;
    c0 = n_trg + n_sec;
    if (s > 1) begin
      repeat ((s - 1) * PER) @(posedge aclk);
      chk(n_trg + n_sec - c0, 0, "early trigger");
    end
    repeat ((s + 3) * PER) @(posedge aclk);
    c0 = n_trg;
    c1 = n_sec;
    c2 = n_irq;
    repeat (4 * (d + 1) * PER) @(posedge aclk);
    chk(n_irq - c2, 4, "irq count");
    chk(n_sec - c1, dm ? 0 : 4 * (d + 1), "separate count");
    chk(n_trg - c0, dm ? 4 * (d + 2) : 4, "trigger count");
  endtask

  // ==========
  // Scenarios
  // ==========
  initial begin
    logic [15:0] io, fc, v;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(rd_q, {16'h0, RSTV[i]}, "reset value");
    end
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      wr(8'(4 * (k % 4)), v);
      rd(8'(4 * (k % 4)));
      chk(rd_q, {16'h0, v & MSKV[k % 4]}, "read back");
      if (k % 4 == 0) chk(alt_dt, v[13:0], "dead time");
    end
    wr(8'h18, 16'hffff);
    chk(resp_q, `RESP_SLVERR, "unmapped write");
    rd(8'h18);
    chk(resp_q, `RESP_SLVERR, "unmapped read");
    // Pair mode is only rewritten while the module is disabled.
    for (int k = 0; k < 40; k++) begin
      io = rnd() & 16'hfffe;
      if (io[11:10] == `PAIR_PUSH_PULL) io[9:8] = 2'b11;
      v = rnd();
      fc = {v[15], 6'h0, v[8], 6'h0, v[1:0] == 2'h0 ? 2'h1 : v[1:0]};
      wr(8'h08, io);
      wr(8'h10, fc);
      {fault_in, limit_in, gen_high, gen_low, gpio_high, gpio_low} <= v[7:2];
      repeat (PER + 6) @(posedge aclk);
      pins(exp_pins(io, fc, v[7:2]));
      chk({hoe, loe}, io[15:14], "owner");
    end
    wr(8'h10, 16'h0000);
    wr(8'h08, 16'hc360);
    fault_in <= 1'b1;
    limit_in <= 1'b0;
    repeat (6) @(posedge aclk);
    fault_in <= 1'b0;
    repeat (PER + 6) @(posedge aclk);
    pins(2'b10);
    rd(8'h14);
    chk(rd_q[0], 1'b1, "latch flag");
    wr(8'h14, 16'h0001);
    repeat (PER + 6) @(posedge aclk);
    pins(2'b01);
    wr(8'h10, 16'h0003);
    wr(8'h08, 16'hc301);
    repeat (PER + 6) @(posedge aclk);
    pins(2'b00);
    do @(negedge aclk); while (!cycle_start);
    @(posedge aclk);
    wr(8'h08, 16'hc3c1);
    pins(2'b00);
    repeat (PER) @(posedge aclk);
    pins(2'b11);
    run_trig(4'h0, 6'h00, 1'b0);
    run_trig(4'hf, 6'h02, 1'b1);
    run_trig(4'h1, 6'h3f, 1'b0);
    v = rnd();
    run_trig(v[3:0], v[9:4], v[10]);
    print_verdict();
  end
  initial begin
    #(100000 * 50);
    miscompares++;
    print_verdict();
  end
endmodule
bind pwm_output_and_trigger_control pwm_out_trig_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .time_base(time_base), .secondary_trigger_event(secondary_trigger_event),
  .gpio_high(gpio_high), .high_side_output(high_side_output),
  .high_pin_oe(high_pin_oe), .adc_trigger(adc_trigger),
  .adc_trigger_secondary(adc_trigger_secondary), .trigger_irq(trigger_irq),
  .alt_dead_time_value(alt_dead_time_value));
`default_nettype wire
